// >>> common/smb_regs.svh
// Register offsets, field positions, reset values and timing for the SMBus sequencer.
`ifndef SMB_REGS_SVH
`define SMB_REGS_SVH
`define SMB_CTRL_OFS  8'h00
`define SMB_DATA_OFS  8'h04
`define SMB_OWN_OFS   8'h08
`define SMB_MASK_OFS  8'h0C
`define SMB_DIV_OFS   8'h10
`define SMB_SI_BIT    0
`define SMB_ACK_BIT   1
`define SMB_START_BIT  2
`define SMB_STOP_BIT   3
`define SMB_NOSLV_BIT  4
`define SMB_ACKREQ_BIT 5
`define SMB_TX_BIT    6
`define SMB_MST_BIT   7
`define SMB_ARB_BIT   8
`define SMB_ERR_BIT   9
`define SMB_BUSY_BIT  10
`define SMB_HWACK_BIT 0
`define SMB_OWN_RST   7'h00
`define SMB_MASK_RST  7'h7F
`define SMB_CLK_MHZ   20
`define SMB_T_HALF_NS 5000
`define SMB_HALF_CYC  ((`SMB_T_HALF_NS * `SMB_CLK_MHZ + 999) / 1000)
`endif

// >>> common/smb_pkg.sv
// Types shared by the SMBus transfer sequencer.
package smb_pkg;
  typedef enum logic [3:0] {
    SMB_IDLE  = 4'h1,
    SMB_START = 4'h2,
    SMB_RUN   = 4'h4,
    SMB_BOUND = 4'h8
  } smb_state_t;
  typedef struct packed {
    logic slv_off;
    logic stop_req;
    logic start_req;
    logic ack;
  } smb_ctrl_t;
endpackage : smb_pkg

// >>> verilog/smb_transfer_sequencer.sv
// SMBus transfer sequencer with APB registers and open-drain bus pins.
//
// Local design decisions: register access over APB and the address map.
`timescale 1ns/1ps
`include "smb_regs.svh"
module smb_transfer_sequencer
  import smb_pkg::*;
#(
  parameter logic [7:0] HALF_CYC = 8'(`SMB_HALF_CYC)
) (
  input  logic        ref_clk,
  input  logic        reset,
  input  logic        psel,
  input  logic        penable,
  input  logic        pwrite,
  input  logic [7:0]  paddr,
  input  logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic        pready,
  output logic        pslverr,
  input  logic        scl_in,
  output logic        scl_out,
  output logic        scl_oe_n,
  input  logic        sda_in,
  output logic        sda_out,
  output logic        sda_oe_n
);
  smb_state_t  st_reg;
  smb_ctrl_t   ctrl_reg;
  logic [2:0]  scl_sync_reg;
  logic [2:0]  sda_sync_reg;
  logic [7:0]  data_reg;
  logic [7:0]  div_reg;
  logic [7:0]  tmr_reg;
  logic [6:0]  own_reg;
  logic [6:0]  mask_reg;
  logic [3:0]  cnt_reg;
  logic [1:0]  si_dly_reg;
  logic [31:0] prdata_reg;
  logic [31:0] rd_mux;
  logic        hwack_reg;
  logic        si_reg;
  logic        ack_request_flag_reg;
  logic        err_reg;
  logic        arb_reg;
  logic        busy_reg;
  logic        data_wr_reg;
  logic        master_reg;
  logic        slv_reg;
  logic        tx_reg;
  logic        addr_reg;
  logic        given_reg;
  logic        ph_reg;
  logic        m_scl_low_reg;
  logic        m_sda_low_reg;
  logic        e_sda_low_reg;
  logic        pready_reg;
  logic        pslverr_reg;
  logic        scl_oe_n_reg;
  logic        sda_oe_n_reg;
  logic        pin_low_reg;
  logic        scl_hi;
  logic        sda_hi;
  logic        scl_rise;
  logic        scl_fall;
  logic        start_det;
  logic        stop_det;
  logic        acc;
  logic        wr;
  logic        hit;
  logic        data_wr;
  logic        ctrl_wr;
  logic        eng;
  logic        ev_rise;
  logic        ev_fall;
  logic        resume;
  logic        match;
  logic        ask;
  logic        reject;
  logic        fin;
  logic        res_bound;
  logic        start_done;
  logic        lose;
  logic        si_set;
  logic        shift_in;
  logic        ack_cap;
  logic        err_set;

  // Only the second and third stages are read; the first stage feeds nothing else.
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      scl_sync_reg <= 3'h7;
      sda_sync_reg <= 3'h7;
    end else begin
      scl_sync_reg <= {scl_sync_reg[1:0], scl_in};
      sda_sync_reg <= {sda_sync_reg[1:0], sda_in};
    end
  end

  assign scl_hi    = scl_sync_reg[1];
  assign sda_hi    = sda_sync_reg[1];
  assign scl_rise  = scl_sync_reg[1] & ~scl_sync_reg[2];
  assign scl_fall  = ~scl_sync_reg[1] & scl_sync_reg[2];
  assign start_det = scl_sync_reg[1] & scl_sync_reg[2] & sda_sync_reg[2] & ~sda_sync_reg[1];
  assign stop_det  = scl_sync_reg[1] & scl_sync_reg[2] & ~sda_sync_reg[2] & sda_sync_reg[1];

  assign acc     = psel & penable;
  assign wr      = acc & pwrite & pready_reg;
  assign data_wr = wr & (paddr == `SMB_DATA_OFS);
  assign ctrl_wr = wr & (paddr == `SMB_CTRL_OFS);

  assign eng        = (master_reg & (st_reg == SMB_RUN)) | slv_reg;
  assign ev_rise    = eng & scl_rise;
  assign ev_fall    = eng & scl_fall;
  assign resume     = eng & si_dly_reg[0] & ~si_reg;
  assign match      = ((data_reg[7:1] ^ own_reg) & mask_reg) == 7'h00;
  assign ask        = ev_fall & (cnt_reg == 4'h8) & ~tx_reg & ~hwack_reg;
  assign reject     = ev_fall & (cnt_reg == 4'h9) & slv_reg & addr_reg & ~given_reg;
  assign fin        = ev_fall & (cnt_reg == 4'h9) & master_reg & ~tx_reg & ~hwack_reg
                      & (ctrl_reg.start_req | ctrl_reg.stop_req);
  assign res_bound  = resume & (cnt_reg == 4'h9) & master_reg & (ctrl_reg.start_req | ctrl_reg.stop_req);
  assign start_done = (st_reg == SMB_START) & (tmr_reg == 8'h00);
  assign lose       = ev_rise & master_reg & tx_reg & ~cnt_reg[3] & ~e_sda_low_reg & ~sda_hi;
  assign si_set     = ask | (ev_fall & (cnt_reg == 4'h9) & ~reject & ~fin) | start_done;
  assign shift_in   = ev_rise & ~cnt_reg[3];
  assign ack_cap    = ev_rise & (cnt_reg == 4'h8) & tx_reg;
  assign err_set    = data_wr & si_reg & slv_reg & tx_reg & ~ctrl_reg.ack;

  always_comb begin
    rd_mux = 32'h0000_0000;
    hit    = 1'b1;
    if (paddr == `SMB_CTRL_OFS) begin
      rd_mux[`SMB_SI_BIT]    = si_reg;
      rd_mux[`SMB_ACK_BIT]   = ctrl_reg.ack;
      rd_mux[`SMB_START_BIT]  = ctrl_reg.start_req;
      rd_mux[`SMB_STOP_BIT]   = ctrl_reg.stop_req;
      rd_mux[`SMB_NOSLV_BIT]  = ctrl_reg.slv_off;
      rd_mux[`SMB_ACKREQ_BIT] = ack_request_flag_reg;
      rd_mux[`SMB_TX_BIT]    = tx_reg;
      rd_mux[`SMB_MST_BIT]   = master_reg;
      rd_mux[`SMB_ARB_BIT]   = arb_reg;
      rd_mux[`SMB_ERR_BIT]   = err_reg;
      rd_mux[`SMB_BUSY_BIT]  = busy_reg;
    end else if (paddr == `SMB_DATA_OFS) begin
      rd_mux[7:0] = data_reg;
    end else if (paddr == `SMB_OWN_OFS) begin
      rd_mux[7:1] = own_reg;
    end else if (paddr == `SMB_MASK_OFS) begin
      rd_mux[7:1]            = mask_reg;
      rd_mux[`SMB_HWACK_BIT] = hwack_reg;
    end else if (paddr == `SMB_DIV_OFS) begin
      rd_mux[7:0] = div_reg;
    end else begin
      hit = 1'b0;
    end
  end

  // One wait state keeps every APB output a plain flip-flop.
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= 32'h0000_0000;
    end else begin
      pready_reg <= acc & ~pready_reg;
      if (acc & ~pready_reg) begin
        prdata_reg  <= pwrite ? 32'h0000_0000 : rd_mux;
        pslverr_reg <= ~hit;
      end else begin
        pslverr_reg <= 1'b0;
      end
    end
  end

  // Hardware sets win over software clears on every flag here.
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      ctrl_reg    <= '0;
      si_reg      <= 1'b0;
      si_dly_reg  <= 2'h0;
      ack_request_flag_reg   <= 1'b0;
      err_reg     <= 1'b0;
      arb_reg     <= 1'b0;
      data_wr_reg <= 1'b0;
      data_reg    <= 8'h00;
      own_reg     <= `SMB_OWN_RST;
      mask_reg    <= `SMB_MASK_RST;
      hwack_reg   <= 1'b0;
      div_reg     <= HALF_CYC;
    end else begin
      if (ctrl_wr) begin
        ctrl_reg.ack <= pwdata[`SMB_ACK_BIT];
        ctrl_reg.start_req <= pwdata[`SMB_START_BIT];
        ctrl_reg.stop_req  <= pwdata[`SMB_STOP_BIT];
        ctrl_reg.slv_off   <= pwdata[`SMB_NOSLV_BIT];
      end
      if (start_done) begin
        ctrl_reg.start_req <= 1'b0;
      end
      if ((st_reg == SMB_BOUND) & ph_reg & scl_hi & (tmr_reg == 8'h00) & ctrl_reg.stop_req) begin
        ctrl_reg.stop_req <= 1'b0;
      end
      if (ack_cap) begin
        ctrl_reg.ack <= ~sda_hi;
      end
      si_reg      <= si_set | (si_reg & ~(ctrl_wr & ~pwdata[`SMB_SI_BIT]));
      si_dly_reg  <= {si_dly_reg[0], si_reg};
      ack_request_flag_reg   <= ask | (ack_request_flag_reg & ~resume);
      err_reg     <= err_set | (err_reg & ~(ctrl_wr & pwdata[`SMB_ERR_BIT]));
      arb_reg     <= lose | (arb_reg & ~start_done);
      data_wr_reg <= data_wr | (data_wr_reg & ~si_set);
      if (data_wr) begin
        data_reg <= pwdata[7:0];
      end else if (shift_in) begin
        data_reg <= {data_reg[6:0], sda_hi};
      end
      if (wr & (paddr == `SMB_OWN_OFS)) begin
        own_reg <= pwdata[7:1];
      end
      if (wr & (paddr == `SMB_MASK_OFS)) begin
        mask_reg  <= pwdata[7:1];
        hwack_reg <= pwdata[`SMB_HWACK_BIT];
      end
      if (wr & (paddr == `SMB_DIV_OFS)) begin
        div_reg <= pwdata[7:0];
      end
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      busy_reg <= 1'b0;
    end else if (start_det) begin
      busy_reg <= 1'b1;
    end else if (stop_det) begin
      busy_reg <= 1'b0;
    end
  end

  // Master timing: start, clock generation with stretching, and stop or repeated start.
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      st_reg        <= SMB_IDLE;
      ph_reg        <= 1'b0;
      tmr_reg       <= 8'h00;
      master_reg    <= 1'b0;
      m_scl_low_reg <= 1'b0;
      m_sda_low_reg <= 1'b0;
    end else begin
      case (st_reg)
        SMB_IDLE: begin
          if (ctrl_reg.start_req & ~busy_reg) begin
            st_reg        <= SMB_START;
            master_reg    <= 1'b1;
            m_sda_low_reg <= 1'b1;
            tmr_reg       <= div_reg;
          end
        end
        SMB_START: begin
          if (tmr_reg == 8'h00) begin
            m_scl_low_reg <= 1'b1;
            st_reg        <= SMB_RUN;
          end else begin
            tmr_reg <= 8'(tmr_reg - 8'h01);
          end
        end
        SMB_RUN: begin
          if (lose) begin
            st_reg        <= SMB_IDLE;
            master_reg    <= 1'b0;
            m_scl_low_reg <= 1'b0;
            m_sda_low_reg <= 1'b0;
          end else if (fin | res_bound) begin
            st_reg        <= SMB_BOUND;
            ph_reg        <= 1'b0;
            m_sda_low_reg <= ctrl_reg.stop_req;
            tmr_reg       <= div_reg;
          end else begin
            if (resume) begin
              m_sda_low_reg <= 1'b0;
            end
            if (m_scl_low_reg) begin
              if (si_reg) begin
                tmr_reg <= div_reg;
              end else if (tmr_reg == 8'h00) begin
                m_scl_low_reg <= 1'b0;
                tmr_reg       <= div_reg;
              end else begin
                tmr_reg <= 8'(tmr_reg - 8'h01);
              end
            end else if (scl_hi) begin
              if (tmr_reg == 8'h00) begin
                m_scl_low_reg <= 1'b1;
                tmr_reg       <= div_reg;
              end else begin
                tmr_reg <= 8'(tmr_reg - 8'h01);
              end
            end
          end
        end
        SMB_BOUND: begin
          if (~ph_reg) begin
            if (tmr_reg == 8'h00) begin
              m_scl_low_reg <= 1'b0;
              ph_reg        <= 1'b1;
              tmr_reg       <= div_reg;
            end else begin
              tmr_reg <= 8'(tmr_reg - 8'h01);
            end
          end else if (scl_hi) begin
            if (tmr_reg != 8'h00) begin
              tmr_reg <= 8'(tmr_reg - 8'h01);
            end else if (ctrl_reg.stop_req) begin
              m_sda_low_reg <= 1'b0;
              master_reg    <= 1'b0;
              st_reg        <= SMB_IDLE;
            end else begin
              m_sda_low_reg <= 1'b1;
              tmr_reg       <= div_reg;
              st_reg        <= SMB_START;
            end
          end
        end
        default: begin
          st_reg <= SMB_IDLE;
        end
      endcase
    end
  end

  // Byte engine shared by all four roles; it steps on bus clock edges and on interrupt release.
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      cnt_reg       <= 4'h0;
      tx_reg        <= 1'b0;
      slv_reg       <= 1'b0;
      addr_reg      <= 1'b0;
      given_reg     <= 1'b0;
      e_sda_low_reg <= 1'b0;
    end else if (start_done) begin
      cnt_reg       <= 4'h9;
      tx_reg        <= 1'b1;
      e_sda_low_reg <= 1'b0;
    end else if (start_det & ~master_reg) begin
      slv_reg       <= ~ctrl_reg.slv_off;
      addr_reg      <= 1'b1;
      cnt_reg       <= 4'h0;
      tx_reg        <= 1'b0;
      e_sda_low_reg <= 1'b0;
    end else if (stop_det & slv_reg) begin
      slv_reg       <= 1'b0;
      tx_reg        <= 1'b0;
      e_sda_low_reg <= 1'b0;
    end else if (lose | fin | res_bound) begin
      e_sda_low_reg <= 1'b0;
      if (lose) begin
        slv_reg <= ~ctrl_reg.slv_off & addr_reg;
        tx_reg  <= 1'b0;
      end
    end else if (reject) begin
      slv_reg       <= 1'b0;
      addr_reg      <= 1'b0;
      e_sda_low_reg <= 1'b0;
    end else begin
      if (data_wr & eng & ~tx_reg) begin
        tx_reg <= 1'b1;
      end
      if (ev_rise) begin
        cnt_reg <= 4'(cnt_reg + 4'h1);
      end
      if (ev_fall) begin
        if (cnt_reg == 4'h8) begin
          if (tx_reg) begin
            e_sda_low_reg <= 1'b0;
          end else if (hwack_reg) begin
            e_sda_low_reg <= (slv_reg & addr_reg) ? match : ctrl_reg.ack;
            given_reg     <= (slv_reg & addr_reg) ? match : ctrl_reg.ack;
          end
        end else if (cnt_reg == 4'h9) begin
          e_sda_low_reg <= 1'b0;
          addr_reg      <= 1'b0;
        end else begin
          e_sda_low_reg <= tx_reg & ~data_reg[7];
        end
      end
      if (resume) begin
        if (cnt_reg == 4'h8) begin
          e_sda_low_reg <= ctrl_reg.ack;
          given_reg     <= ctrl_reg.ack;
        end else if (cnt_reg == 4'h9) begin
          cnt_reg       <= 4'h0;
          tx_reg        <= tx_reg & data_wr_reg;
          e_sda_low_reg <= tx_reg & data_wr_reg & ~data_reg[7];
        end
      end
    end
  end

  // The slave lets go of the clock three cycles after the flag clears, so data has settled first.
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      scl_oe_n_reg <= 1'b1;
      sda_oe_n_reg <= 1'b1;
      pin_low_reg  <= 1'b0;
    end else begin
      scl_oe_n_reg <= ~(m_scl_low_reg | (slv_reg & (si_reg | si_dly_reg[0] | si_dly_reg[1])));
      sda_oe_n_reg <= ~(m_sda_low_reg | e_sda_low_reg);
      pin_low_reg  <= 1'b0;
    end
  end

  assign prdata   = prdata_reg;
  assign pready   = pready_reg;
  assign pslverr  = pslverr_reg;
  assign scl_out  = pin_low_reg;
  assign sda_out  = pin_low_reg;
  assign scl_oe_n = scl_oe_n_reg;
  assign sda_oe_n = sda_oe_n_reg;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  slave_hold_a: assert property (slv_reg && si_reg |=> !scl_oe_n_reg)
    else $error("Slave released SCL while SI set.");
  master_hold_a: assert property (st_reg == SMB_RUN && si_reg && m_scl_low_reg |=> m_scl_low_reg)
    else $error("Master released SCL while SI set.");
  ack_req_a: assert property (ask |=> si_reg && ack_request_flag_reg)
    else $error("No ack request before ack bit.");
  hw_ack_a: assert property (ev_fall && cnt_reg == 4'h8 && !tx_reg && hwack_reg && !addr_reg && !start_det
    && !stop_det |=> e_sda_low_reg == $past(ctrl_reg.ack) && !si_reg)
    else $error("Automatic ack wrong or interrupt early.");
  tx_si_a: assert property (ev_fall && cnt_reg == 4'h9 && tx_reg && !start_det && !stop_det |=> si_reg)
    else $error("No interrupt after transmit ack.");
  to_rx_a: assert property (resume && cnt_reg == 4'h9 && tx_reg && !data_wr_reg && !res_bound && !start_det
    && !stop_det |=> !tx_reg)
    else $error("Mode did not fall back to receive.");
  to_tx_a: assert property (data_wr && eng && !tx_reg && !start_det && !stop_det && !start_done && !lose
    && !fin && !reject |=> tx_reg)
    else $error("Data write did not select transmit.");
  slv_enter_a: assert property (start_det && !master_reg && !start_done && !ctrl_reg.slv_off
    |=> slv_reg && cnt_reg == 4'h0 && !tx_reg)
    else $error("Slave receive not entered on start.");
  reject_a: assert property (reject && !start_done |=> !slv_reg && !si_reg)
    else $error("Rejected address still active.");
  stop_exit_a: assert property (stop_det && slv_reg && !start_done && !start_det |=> !slv_reg)
    else $error("Slave mode kept after stop.");
  err_flag_a: assert property (err_set |=> err_reg)
    else $error("Error not flagged.");
  start_gen_a: assert property (st_reg == SMB_IDLE && ctrl_reg.start_req && !busy_reg
    |=> st_reg == SMB_START && master_reg ##1 !sda_oe_n_reg)
    else $error("Start not generated.");

  start_c: cover property (start_done ##[1:1000] (st_reg == SMB_BOUND));
  slv_tx_c: cover property (slv_reg && tx_reg && si_reg);
  reject_c: cover property (reject);
  lose_c: cover property (lose);
endmodule : smb_transfer_sequencer

// >>> bench/smb_slave_model.sv
// Behavioural SMBus slave that answers the sequencer across the wire.
`timescale 1ns/1ps
module smb_slave_model #(
  parameter logic [6:0] ADDR = 7'h2A
) (
  input  wire logic       scl,
  input  wire logic       sda,
  input  wire logic [7:0] rd_byte,
  output logic            sda_pull_n
);
  logic [7:0] sh;
  logic [7:0] tx;
  logic       active, addr_ph, match, rd, ackv;
  int         bitn;
  logic [7:0] rx_q[$];
  initial begin
    sda_pull_n = 1'b1;
    active = 1'b0;
    ackv = 1'b1;
    rd = 1'b0;
    match = 1'b0;
    bitn = 0;
  end
  always @(negedge sda) begin
    if (scl === 1'b1) begin
      active = 1'b1;
      addr_ph = 1'b1;
      bitn = 0;
    end
  end
  // A stop ends the frame; the released line then shows the pull-up level.
  always @(posedge sda) begin
    if (scl === 1'b1) begin
      active = 1'b0;
    end
  end
  always @(posedge scl) begin
    if (active) begin
      if (bitn < 8) begin
        sh = {sh[6:0], sda};
      end else begin
        ackv = sda;
      end
      bitn = (bitn == 8) ? 0 : bitn + 1;
    end
  end
  // Data moves 100 ns after the falling clock, a hold time that keeps it clear of start and stop detection.
  always @(negedge scl) begin
    if (active) begin
      #100;
      sda_pull_n = 1'b1;
      if (bitn == 8 && addr_ph) begin
        match = (sh[7:1] == ADDR);
        rd = sh[0];
        addr_ph = 1'b0;
        ackv = ~match;
        sda_pull_n = ~match;
      end else if (bitn == 8 && !rd) begin
        rx_q.push_back(sh);
        sda_pull_n = 1'b0;
      end else if (rd && match && !ackv && bitn < 8) begin
        if (bitn == 0) begin
          tx = rd_byte;
        end
        sda_pull_n = tx[7 - bitn];
      end
    end
  end
endmodule : smb_slave_model

// >>> bench/testbench.sv
// Self-checking bench for the SMBus transfer sequencer in master roles.
`timescale 1ns/1ps
`include "smb_regs.svh"
module testbench;
  localparam logic [6:0]  SLV = 7'h2A;
  localparam logic [31:0] ONE = 32'h0000_0001;
  logic        ref_clk, reset, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        scl_oe_n, sda_oe_n, sda_pull_n, scl, sda, scl_o, sda_o;
  int          n_errors, checked;
  assign scl = scl_oe_n;
  assign sda = sda_oe_n & sda_pull_n;
  smb_transfer_sequencer u_dut (
    .ref_clk (ref_clk), .reset (reset), .psel (psel), .penable (penable), .pwrite (pwrite),
    .paddr (paddr), .pwdata (pwdata), .prdata (prdata), .pready (pready), .pslverr (pslverr),
    .scl_in (scl), .scl_out (scl_o), .scl_oe_n (scl_oe_n), .sda_in (sda), .sda_out (sda_o), .sda_oe_n (sda_oe_n));
  smb_slave_model #(.ADDR (SLV)) u_slave (.scl (scl), .sda (sda), .rd_byte (8'hC3), .sda_pull_n (sda_pull_n));
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // Waits for the slave's answer however long it takes; only the watchdog ends a hang.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask : apb
  // Polls the control word; the bound turns a stuck flag into one mismatch.
  task automatic wait_ctrl(input int pos, input logic val);
    int n;
    n = 0;
    do begin
      apb(1'b0, `SMB_CTRL_OFS, '0);
      n++;
    end while (rd[pos] !== val && n < 3000);
    check(rd[pos], val);
  endtask : wait_ctrl
  task automatic send_addr(input logic [6:0] a, input logic dir);
    apb(1'b1, `SMB_CTRL_OFS, ONE << `SMB_START_BIT);
    wait_ctrl(`SMB_SI_BIT, 1'b1);
    check(rd[`SMB_MST_BIT], 1'b1);
    apb(1'b1, `SMB_DATA_OFS, {24'h00_0000, a, dir});
    apb(1'b1, `SMB_CTRL_OFS, '0);
    wait_ctrl(`SMB_SI_BIT, 1'b1);
    check(scl, 1'b0);
    check(u_slave.bitn, 0);
    check(u_slave.rd, dir);
  endtask : send_addr
  task automatic stop_frame;
    apb(1'b1, `SMB_CTRL_OFS, ONE << `SMB_STOP_BIT);
    wait_ctrl(`SMB_BUSY_BIT, 1'b0);
    check(rd[`SMB_MST_BIT], 1'b0);
    check(u_slave.active, 1'b0);
  endtask : stop_frame
  task automatic t_regs;
    apb(1'b0, `SMB_MASK_OFS, '0);
    check(rd, 32'h0000_00FE);
    check({scl_o, sda_o}, 32'h0000_0000);
    apb(1'b0, `SMB_OWN_OFS, '0);
    check(rd, 32'h0000_0000);
    apb(1'b0, `SMB_DIV_OFS, '0);
    check(rd, 32'h0000_0064);
    apb(1'b0, 8'h20, '0);
    check(err, 1'b1);
    check(rd, 32'h0000_0000);
    apb(1'b1, `SMB_DIV_OFS, 32'h0000_0004);
  endtask : t_regs
  task automatic t_mwrite;
    send_addr(SLV, 1'b0);
    check(rd[`SMB_ACK_BIT], 1'b1);
    apb(1'b1, `SMB_DATA_OFS, 32'h0000_00A5);
    apb(1'b1, `SMB_CTRL_OFS, '0);
    wait_ctrl(`SMB_SI_BIT, 1'b1);
    check(rd[`SMB_TX_BIT], 1'b1);
    check(u_slave.bitn, 0);
    check(u_slave.rx_q[0], 32'h0000_00A5);
    stop_frame();
  endtask : t_mwrite
  task automatic t_nack;
    send_addr(SLV ^ 7'h01, 1'b0);
    check(rd[`SMB_ACK_BIT], 1'b0);
    stop_frame();
  endtask : t_nack
  task automatic t_mread;
    send_addr(SLV, 1'b1);
    apb(1'b1, `SMB_CTRL_OFS, '0);
    apb(1'b0, `SMB_CTRL_OFS, '0);
    check(rd[`SMB_TX_BIT], 1'b0);
    wait_ctrl(`SMB_SI_BIT, 1'b1);
    check(rd[`SMB_ACKREQ_BIT], 1'b1);
    check(u_slave.bitn, 8);
    apb(1'b0, `SMB_DATA_OFS, '0);
    check(rd, 32'h0000_00C3);
    apb(1'b1, `SMB_CTRL_OFS, ONE << `SMB_ACK_BIT);
    wait_ctrl(`SMB_SI_BIT, 1'b1);
    check(u_slave.ackv, 1'b0);
    apb(1'b1, `SMB_CTRL_OFS, '0);
    wait_ctrl(`SMB_ACKREQ_BIT, 1'b1);
    stop_frame();
    check(u_slave.ackv, 1'b1);
  endtask : t_mread
  task automatic t_hwack;
    apb(1'b1, `SMB_MASK_OFS, 32'h0000_00FF);
    send_addr(SLV, 1'b1);
    apb(1'b1, `SMB_CTRL_OFS, ONE << `SMB_ACK_BIT);
    wait_ctrl(`SMB_SI_BIT, 1'b1);
    check(u_slave.bitn, 0);
    check(u_slave.ackv, 1'b0);
    apb(1'b1, `SMB_DATA_OFS, 32'h0000_0011);
    apb(1'b0, `SMB_CTRL_OFS, '0);
    check(rd[`SMB_TX_BIT], 1'b1);
    stop_frame();
  endtask : t_hwack
  task automatic final_report;
    $display("checks %0d errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : final_report
  initial begin
    n_errors = 0;
    checked = 0;
    reset = 1'b1;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    repeat (3) @(posedge ref_clk);
    reset <= 1'b0;
    @(posedge ref_clk);
    t_regs();
    t_mwrite();
    t_nack();
    t_mread();
    t_hwack();
    final_report();
  end
  // Whole run needs a few thousand cycles; this limit only catches a hang.
  initial begin
    repeat (60000) @(posedge ref_clk);
    n_errors++;
    final_report();
  end
endmodule : testbench
